// *** cmoid_pkg.sv ***
// Constants and types for the message object tag, mask and data block
//==========================================================================
// Summary of operation
// - Standard 11-bit ID in tag 31:21
// - Extended 29-bit ID in tag 31:3
// - Received frame overwrites stored identifier
// - Unused standard bits never compared
// - Remote request tag; cleared before auto reply
// - Extended bit 1 holds reserved bit one
// - Bit 0 holds reserved bit zero
// - Standard mask 31:21 enables ID compare
// - Extended mask 31:3 enables ID compare
// - Mask bit 2 gates remote request compare
// - Mask bit 0 gates extension flag compare
// - Sixteen-bit time stamp, low/high bytes
// - Data window reads paged object at index
// - Index advances after each data access
// - Index wraps modulo eight
// - Page selects object 0-14 and index
// - Active-low auto increment control
// - Extension flag picks 11/29-bit layout
package cmoid_pkg;

    //======================================================================
    // Sizes
    localparam int NUM_OBJ  = 15;
    localparam int NUM_BYTE = 8;

    //======================================================================
    // Register byte addresses
    localparam logic [4:0] ADR_PAGE   = 5'h00;
    localparam logic [4:0] ADR_CFG    = 5'h01;
    localparam logic [4:0] ADR_RXEN_L = 5'h02;
    localparam logic [4:0] ADR_RXEN_H = 5'h03;
    localparam logic [4:0] ADR_TAG1   = 5'h04;
    localparam logic [4:0] ADR_TAG2   = 5'h05;
    localparam logic [4:0] ADR_TAG3   = 5'h06;
    localparam logic [4:0] ADR_TAG4   = 5'h07;
    localparam logic [4:0] ADR_MSK1   = 5'h08;
    localparam logic [4:0] ADR_MSK2   = 5'h09;
    localparam logic [4:0] ADR_MSK3   = 5'h0A;
    localparam logic [4:0] ADR_MSK4   = 5'h0B;
    localparam logic [4:0] ADR_STM_L  = 5'h0C;
    localparam logic [4:0] ADR_STM_H  = 5'h0D;
    localparam logic [4:0] ADR_MSG    = 5'h0E;

    //======================================================================
    // Field positions
    localparam int PG_OBJ_LSB = 4;
    localparam int PG_HOLD    = 3;
    localparam int TAG_RTR    = 2;
    localparam int TAG_RB1    = 1;
    localparam int TAG_RB0    = 0;
    localparam int MSK_IDE    = 0;

    //======================================================================
    // Compare windows per layout and reset values
    localparam logic [31:0] CARE_STD  = 32'hFFE00004;
    localparam logic [31:0] CARE_EXT  = 32'hFFFFFFFC;
    localparam logic [7:0]  PAGE_RST  = 8'h00;

    //======================================================================
    // Frame from the protocol engine
    typedef struct packed {
        logic        valid;
        logic [28:0] id;
        logic        extended_id_flag;
        logic        rtr;
        logic        rb1;
        logic        rb0;
        logic [15:0] stamp;
        logic [63:0] data;
    } cmoid_rx_s;

    //======================================================================
    // Complete block state
    typedef struct packed {
        logic [7:0]                   page;
        logic [NUM_OBJ-1:0]           ext;
        logic [NUM_OBJ-1:0]           rx_en;
        logic [NUM_OBJ-1:0][31:0]     tag;
        logic [NUM_OBJ-1:0][31:0]     msk;
        logic [NUM_OBJ-1:0][15:0]     stm;
        logic [NUM_OBJ-1:0][7:0][7:0] buf_d;
        logic [7:0]                   rdata;
        logic [31:0]                  tx_tag;
        logic                         tx_ide;
        logic                         st_vld;
        logic [3:0]                   st_obj;
    } cmoid_state_s;

endpackage : cmoid_pkg

// *** cmoid_regs.sv ***
// Message object identifier tag, mask, time stamp and data window
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
module cmoid_regs
    import cmoid_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RSTN_I,
    // Register port
    input  wire logic [4:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // Received frame
    input  wire cmoid_rx_s  RX_FRAME_I,
    output logic [14:0]     ACCEPT_O,
    output logic            STORE_VLD_O,
    output logic [3:0]      STORE_OBJ_O,
    // Transmit side
    input  wire logic [3:0] TX_SEL_I,
    output logic [31:0]     TX_TAG_O,
    output logic            TX_IDE_O,
    // Automatic reply
    input  wire logic       REPLY_CLR_I,
    input  wire logic [3:0] REPLY_OBJ_I
);

    //======================================================================
    // Reset release
    logic        rst_a_ff;
    logic        rst_b_ff;
    logic        rstn;

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    assign rstn = rst_b_ff;

    //======================================================================
    // State
    cmoid_state_s st_ff;
    cmoid_state_s nxt_st;

    logic [3:0]  pg_obj;
    logic [2:0]  pg_idx;
    logic        pg_ok;
    logic [31:0] rx_word;
    logic [31:0] rx_care;
    logic [14:0] hit;
    logic [3:0]  first;
    logic        any_hit;

    assign pg_obj = st_ff.page[7:PG_OBJ_LSB];
    assign pg_idx = st_ff.page[2:0];
    assign pg_ok  = (pg_obj < 4'hF);

    //======================================================================
    // Received word in tag layout
    always_comb begin
        if (RX_FRAME_I.extended_id_flag) begin
            rx_word = {RX_FRAME_I.id, RX_FRAME_I.rtr,
                       RX_FRAME_I.rb1, RX_FRAME_I.rb0};
        end else begin
            rx_word = {RX_FRAME_I.id[10:0], 18'h00000,
                       RX_FRAME_I.rtr, RX_FRAME_I.rb1,
                       RX_FRAME_I.rb0};
        end
    end

    //======================================================================
    // Acceptance filter per object
    genvar g;
    generate
        for (g = 0; g < NUM_OBJ; g++) begin : g_flt
            logic [31:0] care;
            logic        id_ok;
            logic        ide_ok;
            assign care   = st_ff.ext[g] ? CARE_EXT
                                         : CARE_STD;
            assign id_ok  = ((st_ff.tag[g] ^ rx_word)
                             & st_ff.msk[g] & care) == 32'h0;
            assign ide_ok = !st_ff.msk[g][MSK_IDE]
                            || (st_ff.ext[g] == RX_FRAME_I.extended_id_flag);
            assign hit[g] = RX_FRAME_I.valid && st_ff.rx_en[g]
                            && id_ok && ide_ok;
        end
    endgenerate

    assign rx_care  = RX_FRAME_I.extended_id_flag ? CARE_EXT : CARE_STD;
    assign ACCEPT_O = hit;
    assign any_hit  = |hit;

    // Lowest object wins when several hit
    always_comb begin
        first = 4'h0;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (hit[i]) begin
                first = 4'(i);
            end
        end
    end

    //======================================================================
    // Next state
    always_comb begin
        logic [7:0]  rd;
        logic [31:0] wtag;
        nxt_st = st_ff;
        rd     = 8'h00;
        wtag   = 32'h0;

        // Transmit view is registered
        if (TX_SEL_I < 4'hF) begin
            nxt_st.tx_tag = st_ff.tag[TX_SEL_I];
            nxt_st.tx_ide = st_ff.ext[TX_SEL_I];
        end else begin
            nxt_st.tx_tag = 32'h0;
            nxt_st.tx_ide = 1'b0;
        end

        // Software writes
        if (WR_I) begin
            case (ADDR_I)
                ADR_PAGE: begin
                    nxt_st.page = WDATA_I;
                end
                ADR_CFG: begin
                    if (pg_ok) begin
                        nxt_st.ext[pg_obj] = WDATA_I[0];
                    end
                end
                ADR_RXEN_L: begin
                    nxt_st.rx_en[7:0] = WDATA_I;
                end
                ADR_RXEN_H: begin
                    nxt_st.rx_en[14:8] = WDATA_I[6:0];
                end
                ADR_TAG1: begin
                    if (pg_ok) begin
                        nxt_st.tag[pg_obj][31:24] = WDATA_I;
                    end
                end
                ADR_TAG2: begin
                    if (pg_ok) begin
                        nxt_st.tag[pg_obj][23:16] = WDATA_I;
                    end
                end
                ADR_TAG3: begin
                    if (pg_ok) begin
                        nxt_st.tag[pg_obj][15:8] = WDATA_I;
                    end
                end
                ADR_TAG4: begin
                    if (pg_ok) begin
                        nxt_st.tag[pg_obj][7:0] = WDATA_I;
                    end
                end
                ADR_MSK1: begin
                    if (pg_ok) begin
                        nxt_st.msk[pg_obj][31:24] = WDATA_I;
                    end
                end
                ADR_MSK2: begin
                    if (pg_ok) begin
                        nxt_st.msk[pg_obj][23:16] = WDATA_I;
                    end
                end
                ADR_MSK3: begin
                    if (pg_ok) begin
                        nxt_st.msk[pg_obj][15:8] = WDATA_I;
                    end
                end
                ADR_MSK4: begin
                    if (pg_ok) begin
                        nxt_st.msk[pg_obj][7:0] = WDATA_I;
                    end
                end
                ADR_MSG: begin
                    if (pg_ok) begin
                        nxt_st.buf_d[pg_obj][pg_idx] = WDATA_I;
                    end
                    if (!st_ff.page[PG_HOLD]) begin
                        nxt_st.page[2:0] = pg_idx + 3'h1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Software reads, data stands one cycle
        if (RD_I && pg_ok) begin
            case (ADDR_I)
                ADR_TAG1:  rd = st_ff.tag[pg_obj][31:24];
                ADR_TAG2:  rd = st_ff.tag[pg_obj][23:16];
                ADR_TAG3:  rd = st_ff.tag[pg_obj][15:8];
                ADR_TAG4:  rd = st_ff.tag[pg_obj][7:0];
                ADR_MSK1:  rd = st_ff.msk[pg_obj][31:24];
                ADR_MSK2:  rd = st_ff.msk[pg_obj][23:16];
                ADR_MSK3:  rd = st_ff.msk[pg_obj][15:8];
                ADR_MSK4:  rd = st_ff.msk[pg_obj][7:0];
                ADR_STM_L: rd = st_ff.stm[pg_obj][7:0];
                ADR_STM_H: rd = st_ff.stm[pg_obj][15:8];
                ADR_MSG:   rd = st_ff.buf_d[pg_obj][pg_idx];
                ADR_CFG:   rd = {7'h00, st_ff.ext[pg_obj]};
                default:   rd = 8'h00;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                ADR_PAGE:   rd = st_ff.page;
                ADR_RXEN_L: rd = st_ff.rx_en[7:0];
                ADR_RXEN_H: rd = {1'b0, st_ff.rx_en[14:8]};
                default: begin
                end
            endcase
            if (ADDR_I == ADR_MSG && !st_ff.page[PG_HOLD]) begin
                nxt_st.page[2:0] = pg_idx + 3'h1;
            end
        end
        nxt_st.rdata = rd;

        // Store received frame into lowest hit
        nxt_st.st_vld = any_hit;
        nxt_st.st_obj = any_hit ? first : 4'h0;
        if (any_hit) begin
            wtag = (st_ff.tag[first] & ~rx_care)
                   | (rx_word & rx_care);
            wtag[TAG_RB0] = RX_FRAME_I.rb0;
            wtag[TAG_RB1] = RX_FRAME_I.extended_id_flag ? RX_FRAME_I.rb1
                                           : 1'b0;
            nxt_st.tag[first]    = wtag;
            nxt_st.ext[first]    = RX_FRAME_I.extended_id_flag;
            nxt_st.stm[first]    = RX_FRAME_I.stamp;
            nxt_st.buf_d[first]  = RX_FRAME_I.data;
            nxt_st.rx_en[first]  = 1'b0;
        end

        // Reply clears remote request before sending
        if (REPLY_CLR_I && REPLY_OBJ_I < 4'hF) begin
            nxt_st.tag[REPLY_OBJ_I][TAG_RTR] = 1'b0;
        end
    end

    //======================================================================
    // Registers; storage reset only for determinism
    always_ff @(posedge CLK_I or negedge rstn) begin
        if (!rstn) begin
            st_ff      <= '0;
            st_ff.page <= PAGE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    //======================================================================
    // Outputs
    assign RDATA_O     = st_ff.rdata;
    assign TX_TAG_O    = st_ff.tx_tag;
    assign TX_IDE_O    = st_ff.tx_ide;
    assign STORE_VLD_O = st_ff.st_vld;
    assign STORE_OBJ_O = st_ff.st_obj;

endmodule : cmoid_regs

// *** cmoid_checker.sv ***
// Port assertions for the message object register block
`timescale 1ns/1ns
module cmoid_checker
    import cmoid_pkg::*;
(
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        RSTN_I,
    // Register port
    input wire logic [4:0]  ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [7:0]  RDATA_O,
    // Receive side
    input wire cmoid_rx_s   RX_FRAME_I,
    input wire logic [14:0] ACCEPT_O,
    input wire logic        STORE_VLD_O,
    input wire logic [3:0]  STORE_OBJ_O,
    // Transmit and reply
    input wire logic [3:0]  TX_SEL_I,
    input wire logic [31:0] TX_TAG_O,
    input wire logic        TX_IDE_O,
    input wire logic        REPLY_CLR_I,
    input wire logic [3:0]  REPLY_OBJ_I
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    //==================================================================
    // Lowest hit
    logic [3:0] low_idx;
    always_comb begin
        low_idx = 4'h0;
        for (int k = NUM_OBJ - 1; k >= 0; k--) begin
            if (ACCEPT_O[k]) low_idx = 4'(k);
        end
    end
    //==================================================================
    // Properties
    sequence s_reply_view;
        REPLY_CLR_I && REPLY_OBJ_I == TX_SEL_I && REPLY_OBJ_I != 4'hF
        ##1 TX_SEL_I == $past(TX_SEL_I);
    endsequence
    property p_rd_idle;
        !RD_I |=> RDATA_O == 8'h00;
    endproperty
    property p_rd_unmap;
        RD_I && ADDR_I == 5'h1F |=> RDATA_O == 8'h00;
    endproperty
    property p_acc_gate;
        !RX_FRAME_I.valid |-> ACCEPT_O == 15'h0000;
    endproperty
    property p_hit_store;
        |ACCEPT_O |=> STORE_VLD_O && STORE_OBJ_O == $past(low_idx);
    endproperty
    property p_store_cause;
        STORE_VLD_O |-> $past(|ACCEPT_O);
    endproperty
    property p_obj_idle;
        !STORE_VLD_O |-> STORE_OBJ_O == 4'h0;
    endproperty
    property p_tx_none;
        TX_SEL_I == 4'hF |=> TX_TAG_O == 32'h0;
    endproperty
    property p_reply;
        s_reply_view |=> !TX_TAG_O[2];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    a_acc_gate: assert property (p_acc_gate) else $error("hit without frame");
    a_hit_store: assert property (p_hit_store) else $error("hit not stored");
    a_store_cause: assert property (p_store_cause) else $error("store without hit");
    a_obj_idle: assert property (p_obj_idle) else $error("object number not idle");
    a_tx_none: assert property (p_tx_none) else $error("tag of object 15");
    a_reply: assert property (p_reply) else $error("remote tag not cleared");
endmodule : cmoid_checker

bind cmoid_regs cmoid_checker i_chk (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .RX_FRAME_I(RX_FRAME_I), .ACCEPT_O(ACCEPT_O),
    .STORE_VLD_O(STORE_VLD_O), .STORE_OBJ_O(STORE_OBJ_O), .TX_SEL_I(TX_SEL_I),
    .TX_TAG_O(TX_TAG_O), .TX_IDE_O(TX_IDE_O), .REPLY_CLR_I(REPLY_CLR_I),
    .REPLY_OBJ_I(REPLY_OBJ_I));

// *** cmoid_node.sv ***
// Remote bus node model that presents received frames
`timescale 1ns/1ns
module cmoid_node
    import cmoid_pkg::*;
(
    // Clock
    input  wire logic        clk_i,
    // Hit vector from block
    input  wire logic [14:0] acc_i,
    // Frame toward block
    output cmoid_rx_s        frm_o
);
    initial frm_o = '0;
    //==================================================================
    // One frame, valid one cycle, then fields scrambled
    task automatic send(input logic [28:0] id, input logic [3:0] b,
                        input logic [15:0] s, output logic [14:0] acc);
        @(posedge clk_i);
        frm_o <= '{1'b1, id, b[3], b[2], b[1], b[0], s, 64'h0706050403020100};
        #1 acc = acc_i;
        @(posedge clk_i);
        frm_o <= {1'b0, ~frm_o[112:0]};
    endtask : send
endmodule : cmoid_node

// *** cmoid_tb.sv ***
// Self-checking bench for the message object register block
`timescale 1ns/1ns
module testbench
    import cmoid_pkg::*;
;
    logic        clk, rst_n, wr, rd, rep_clr, st_vld, tx_ide;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [14:0] acc;
    logic [3:0]  st_obj, tx_sel, rep_obj;
    logic [31:0] tx_tag;
    cmoid_rx_s   frm;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;
    cmoid_regs i_dut (.CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RX_FRAME_I(frm), .ACCEPT_O(acc),
        .STORE_VLD_O(st_vld), .STORE_OBJ_O(st_obj), .TX_SEL_I(tx_sel), .TX_TAG_O(tx_tag),
        .TX_IDE_O(tx_ide), .REPLY_CLR_I(rep_clr), .REPLY_OBJ_I(rep_obj));
    cmoid_node i_node (.clk_i(clk), .acc_i(acc), .frm_o(frm));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    //==================================================================
    // Shared tasks
    task automatic results;
        if (errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_r(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_r
    task automatic rd_r(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(64'(rdata), 64'(e));
    endtask : rd_r
    task automatic wr4(input logic [4:0] a, input logic [31:0] v);
        for (int k = 0; k < 4; k++) wr_r(a + 5'(k), v[31 - 8 * k -: 8]);
    endtask : wr4
    task automatic rx(input logic [28:0] id, input logic [3:0] b, input logic [15:0] s,
                      input logic [14:0] e);
        logic [14:0] got;
        logic [3:0]  lo;
        lo = 4'h0;
        for (int k = NUM_OBJ - 1; k >= 0; k--) if (e[k]) lo = 4'(k);
        i_node.send(id, b, s, got);
        chk(64'(got), 64'(e));
        #1 chk(64'(st_vld), 64'(e != 15'h0));
        chk(64'(st_obj), 64'(lo));
    endtask : rx
    //==================================================================
    // Scenarios
    task automatic t_window;
        rd_r(ADR_PAGE, PAGE_RST);
        wr_r(ADR_PAGE, 8'h36);
        for (int k = 0; k < 8; k++) wr_r(ADR_MSG, 8'hA0 + 8'(k));
        rd_r(ADR_PAGE, 8'h36);
        wr_r(ADR_PAGE, 8'h30);
        for (int k = 0; k < 8; k++) rd_r(ADR_MSG, 8'hA0 + 8'((k + 2) % 8));
        wr_r(ADR_PAGE, 8'h3A);
        rd_r(ADR_MSG, 8'hA4);
        rd_r(ADR_PAGE, 8'h3A);
    endtask : t_window
    task automatic t_std;
        wr_r(ADR_PAGE, 8'h10);
        wr_r(ADR_CFG, 8'h00);
        wr4(ADR_TAG1, 32'hB4A00000);
        wr4(ADR_MSK1, 32'hFFE00005);
        wr_r(ADR_RXEN_L, 8'h02);
        rx(29'h5A4, 4'b0000, 16'h0000, 15'h0000);
        rx(29'h5A5, 4'b0100, 16'h0000, 15'h0000);
        rx(29'h16940000, 4'b1000, 16'h0000, 15'h0000);
        rx(29'h5A5, 4'b0001, 16'hFFFE, 15'h0002);
        rd_r(ADR_TAG1, 8'hB4);
        rd_r(ADR_TAG4, 8'h01);
        rd_r(ADR_STM_L, 8'hFE);
        rd_r(ADR_STM_H, 8'hFF);
        wr_r(ADR_PAGE, 8'h10);
        for (int k = 0; k < 8; k++) rd_r(ADR_MSG, 8'(k));
    endtask : t_std
    task automatic t_ext;
        wr_r(ADR_PAGE, 8'h20);
        wr_r(ADR_CFG, 8'h01);
        wr4(ADR_TAG1, 32'hD5E6F780);
        wr4(ADR_MSK1, 32'hFFFFFFF1);
        wr_r(ADR_RXEN_L, 8'h04);
        rx(29'h1ABCDEF1, 4'b0111, 16'h0000, 15'h0000);
        rx(29'h1ABCDEF1, 4'b1111, 16'h0000, 15'h0004);
        @(posedge clk);
        tx_sel <= 4'h2;
        repeat (2) @(posedge clk);
        #1 chk(64'(tx_tag), 64'hD5E6F78F);
        chk(64'(tx_ide), 64'h1);
        @(posedge clk);
        rep_clr <= 1'b1;
        rep_obj <= 4'h2;
        @(posedge clk);
        rep_clr <= 1'b0;
        @(posedge clk);
        #1 chk(64'(tx_tag), 64'hD5E6F78B);
    endtask : t_ext
    task automatic t_refuse;
        wr_r(ADR_PAGE, 8'hF0);
        rd_r(ADR_TAG1, 8'h00);
        rd_r(5'h1F, 8'h00);
        @(posedge clk);
        tx_sel <= 4'hF;
        repeat (2) @(posedge clk);
        #1 chk(64'(tx_tag), 64'h0);
    endtask : t_refuse
    //==================================================================
    // Timeout and main sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        tx_sel = 4'h0;
        rep_clr = 1'b0;
        rep_obj = 4'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_window();
        t_std();
        t_ext();
        t_refuse();
        results();
    end
endmodule : testbench
